// [wdslp_top.sv]
// Purpose: watchdog timer with sleep entry and wake-up control, registers on classic wishbone
// Assumes: core_clk is the system clock; instruction strobes come from the core on core_clk
// Notes:   core_clk keeps running in sleep; the stopped system clock is modelled by gating
//
// The Wishbone register port and the address map were left to the implementer.
`include "wdslp_consts.svh"

module wdslp_top #(
  parameter int IRQ_N       = 4,
  parameter int RSTD_CYC    = `WDSLP_RSTD_MS * `WDSLP_CLK_KHZ,
  parameter int SST_CYC     = `WDSLP_SST_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [7:0]       wb_adr,
  input  wire logic [3:0]       wb_sel,
  input  wire logic [31:0]      wb_dat_w,
  output logic      [31:0]      wb_dat_r,
  output logic                  wb_ack,
  input  wire logic             low_speed_rc_clock,
  input  wire logic             external_reset_pin_n,
  input  wire logic [7:0]       port_a_pins,
  input  wire logic [7:0]       port_a_wake_enable,
  input  wire logic [IRQ_N-1:0] irq_request,
  input  wire logic [IRQ_N-1:0] irq_enable,
  input  wire logic             stack_full,
  input  wire logic             sleep_instruction,
  input  wire logic             watchdog_clear_instruction,
  output logic                  mcu_reset,
  output logic                  pc_sp_reset,
  output logic                  cpu_hold,
  output logic                  sys_osc_en,
  output logic                  sleeping,
  output logic                  wake_resume,
  output logic                  irq_service,
  output logic                  timeout_flag,
  output logic                  power_down_flag,
  output logic                  watchdog_running
);

  // division limit for a timeout select code
  function automatic logic [`WDSLP_CNT_W-1:0] wdslp_limit(input logic [2:0] code);
    logic [`WDSLP_CNT_W:0] one;
    logic [`WDSLP_CNT_W:0] span;
    one  = {{`WDSLP_CNT_W{1'b0}}, 1'b1};
    span = (one << (`WDSLP_DIV_BASE + code)) - 1'b1;
    wdslp_limit = span[`WDSLP_CNT_W-1:0];
  endfunction

  wdslp_pkg::wdslp_state_t state_q;

  logic [2:0]              tsel_q;
  logic [1:0]              cls_q;
  logic [5:0]              key_q;
  logic                    to_q;
  logic                    pwrdn_q;
  logic [`WDSLP_CNT_W-1:0] cnt_q;
  logic [1:0]              div4_q;
  logic [1:0]              bad_ticks_q;
  logic [31:0]             dly_q;
  logic                    rstd_done_q;
  logic                    cause_irq_q;
  logic                    cause_wdt_q;
  logic [IRQ_N-1:0]        irq_snap_q;
  logic [IRQ_N-1:0]        wake_irq_q;
  logic                    ack_q;
  logic [31:0]             rdat_q;
  logic                    pc_sp_q;
  logic                    resume_q;
  logic                    service_q;

  // two-flop synchronisers on every pin input
  logic [2:0] rc_sync_q;
  logic [1:0] rst_pin_sync_q;
  logic [7:0] pa_meta_q;
  logic [7:0] pa_sync_q;
  logic [7:0] pa_prev_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rc_sync_q      <= 3'h0;
      rst_pin_sync_q <= 2'h3;
      pa_meta_q      <= 8'hff;
      pa_sync_q      <= 8'hff;
      pa_prev_q      <= 8'hff;
    end else begin
      rc_sync_q      <= {rc_sync_q[1:0], low_speed_rc_clock};
      rst_pin_sync_q <= {rst_pin_sync_q[0], external_reset_pin_n};
      pa_meta_q      <= port_a_pins;
      pa_sync_q      <= pa_meta_q;
      pa_prev_q      <= pa_sync_q;
    end
  end

  logic rc_tick;
  logic pin_low;
  logic pa_fall;
  assign rc_tick   = rc_sync_q[1] & ~rc_sync_q[2];
  assign pin_low   = ~rst_pin_sync_q[1];
  assign pa_fall   = |(pa_prev_q & ~pa_sync_q & port_a_wake_enable & `WDSLP_PA_WAKE_MASK);

  logic in_run;
  logic in_sleep;
  logic in_wake;
  logic in_rst;
  assign in_run   = (state_q == wdslp_pkg::WDSLP_RUN);
  assign in_sleep = (state_q == wdslp_pkg::WDSLP_SLEEP);
  assign in_wake  = (state_q == wdslp_pkg::WDSLP_WAKE);
  assign in_rst   = (state_q == wdslp_pkg::WDSLP_RST);

  logic key_en;
  logic key_bad;
  logic clr_ins;
  logic sleep_go;
  assign key_en   = (key_q == `WDSLP_KEY_ENABLE);
  assign key_bad  = ~key_en & (key_q != `WDSLP_KEY_DISABLE);
  assign clr_ins  = watchdog_clear_instruction & key_en & in_run;
  assign sleep_go = sleep_instruction & in_run;

  // source tick; system-derived sources vanish while the system clock is stopped
  logic sys_live;
  logic src_tick;
  assign sys_live = in_run | in_wake;
  always_comb begin
    if (cls_q == `WDSLP_CLS_SLOW_RC) begin
      src_tick = rc_tick;
    end else if (cls_q == `WDSLP_CLS_DIV4) begin
      src_tick = sys_live & (div4_q == 2'h3);
    end else begin
      src_tick = sys_live;
    end
  end

  logic overflow;
  assign overflow = key_en & src_tick & (cnt_q == wdslp_limit(tsel_q)) & ~in_rst;

  // fires on the third RC edge seen while the key is bad: 2 to 3 RC periods after the write
  logic key_reset;
  assign key_reset = key_bad & rc_tick & (bad_ticks_q == `WDSLP_KEY_DLY_TICKS);

  logic full_reset;
  assign full_reset = pin_low | key_reset | (overflow & in_run);

  logic [IRQ_N-1:0] irq_new;
  logic             wake_evt;
  assign irq_new  = irq_request & ~irq_snap_q;
  assign wake_evt = pa_fall | (|irq_new);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div4_q <= 2'h0;
    end else if (sys_live) begin
      div4_q <= div4_q + 2'h1;
    end
  end

  // watchdog counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (pin_low | key_bad | sleep_go | clr_ins | in_rst) begin
      cnt_q <= '0;
    end else if (~key_en) begin
      cnt_q <= '0;
    end else if (overflow) begin
      cnt_q <= '0;
    end else if (src_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bad_ticks_q <= 2'h0;
    end else if (~key_bad) begin
      bad_ticks_q <= 2'h0;
    end else if (rc_tick) begin
      bad_ticks_q <= bad_ticks_q + 2'h1;
    end
  end

  // power state machine
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= wdslp_pkg::WDSLP_RUN;
    end else begin
      case (state_q)
        wdslp_pkg::WDSLP_RUN: begin
          if (full_reset) begin
            state_q <= wdslp_pkg::WDSLP_RST;
          end else if (sleep_go) begin
            state_q <= wdslp_pkg::WDSLP_SLEEP;
          end
        end
        wdslp_pkg::WDSLP_SLEEP: begin
          if (pin_low | key_reset) begin
            state_q <= wdslp_pkg::WDSLP_RST;
          end else if (overflow | wake_evt) begin
            state_q <= wdslp_pkg::WDSLP_WAKE;
          end
        end
        wdslp_pkg::WDSLP_WAKE: begin
          if (full_reset) begin
            state_q <= wdslp_pkg::WDSLP_RST;
          end else if (dly_q == 32'(SST_CYC - 1)) begin
            state_q <= wdslp_pkg::WDSLP_RUN;
          end
        end
        wdslp_pkg::WDSLP_RST: begin
          if (rstd_done_q & ~pin_low) begin
            state_q <= wdslp_pkg::WDSLP_WAKE;
          end
        end
        default: begin
          state_q <= wdslp_pkg::WDSLP_RUN;
        end
      endcase
    end
  end

  // shared delay counter: reset delay in the reset state, start-up delay in wake
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_q       <= 32'h0;
      rstd_done_q <= 1'b0;
    end else if (in_rst) begin
      if (pin_low) begin
        dly_q       <= 32'h0;
        rstd_done_q <= 1'b0;
      end else if (rstd_done_q) begin
        dly_q <= 32'h0;
      end else if (dly_q == 32'(RSTD_CYC - 1)) begin
        dly_q       <= 32'h0;
        rstd_done_q <= 1'b1;
      end else begin
        dly_q <= dly_q + 32'h1;
      end
    end else if (in_wake) begin
      dly_q       <= dly_q + 32'h1;
      rstd_done_q <= 1'b0;
    end else begin
      dly_q       <= 32'h0;
      rstd_done_q <= 1'b0;
    end
  end

  // wake cause and snapshot of requests already pending at sleep entry
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_snap_q  <= '0;
      wake_irq_q  <= '0;
      cause_irq_q <= 1'b0;
      cause_wdt_q <= 1'b0;
    end else if (sleep_go) begin
      irq_snap_q  <= irq_request;
      cause_irq_q <= 1'b0;
      cause_wdt_q <= 1'b0;
    end else if (in_sleep & ~(pin_low | key_reset)) begin
      if (overflow) begin
        cause_wdt_q <= 1'b1;
      end else if (|irq_new) begin
        cause_irq_q <= 1'b1;
        wake_irq_q  <= irq_new;
      end
    end else if (in_rst) begin
      cause_irq_q <= 1'b0;
      cause_wdt_q <= 1'b0;
    end
  end

  // one-cycle outcome strobes
  logic wake_end;
  assign wake_end = in_wake & ~full_reset & (dly_q == 32'(SST_CYC - 1));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_sp_q   <= 1'b0;
      resume_q  <= 1'b0;
      service_q <= 1'b0;
    end else begin
      pc_sp_q   <= in_sleep & overflow & ~(pin_low | key_reset);
      service_q <= wake_end & cause_irq_q & (|(wake_irq_q & irq_enable)) & ~stack_full;
      // a disabled source or full stack leaves the request pending upstream
      resume_q  <= wake_end & ~cause_wdt_q & ~(cause_irq_q & (|(wake_irq_q & irq_enable))
                   & ~stack_full);
    end
  end

  // status flags; hardware set beats a same-cycle clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      to_q <= 1'b0;
    end else if (overflow) begin
      to_q <= 1'b1;
    end else if (sleep_go | clr_ins) begin
      to_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwrdn_q <= 1'b0;
    end else if (sleep_go) begin
      pwrdn_q <= 1'b1;
    end else if (clr_ins) begin
      pwrdn_q <= 1'b0;
    end
  end

  // register bus: one-cycle ack, every request answered
  logic req;
  logic wr_lo;
  assign req   = wb_cyc & wb_stb & ~ack_q;
  assign wr_lo = req & wb_we & wb_sel[0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tsel_q <= `WDSLP_TSEL_RST;
      cls_q  <= `WDSLP_CLS_RST;
      key_q  <= `WDSLP_KEY_RST;
    end else if (in_rst) begin
      // a device reset returns the control registers to their defaults
      tsel_q <= `WDSLP_TSEL_RST;
      cls_q  <= `WDSLP_CLS_RST;
      key_q  <= `WDSLP_KEY_RST;
    end else if (wr_lo && wb_adr == `WDSLP_ADR_TSEL) begin
      tsel_q <= wb_dat_w[`WDSLP_TSEL_HI:0];
    end else if (wr_lo && wb_adr == `WDSLP_ADR_CTRL) begin
      cls_q  <= wb_dat_w[`WDSLP_CLS_HI:`WDSLP_CLS_LO];
      key_q  <= wb_dat_w[`WDSLP_KEY_HI:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= req;
      rdat_q <= 32'h0;
      if (req && wb_adr == `WDSLP_ADR_TSEL) begin
        rdat_q[`WDSLP_TSEL_HI:0] <= tsel_q;
      end else if (req && wb_adr == `WDSLP_ADR_CTRL) begin
        rdat_q[`WDSLP_CLS_HI:`WDSLP_CLS_LO] <= cls_q;
        rdat_q[`WDSLP_KEY_HI:0]             <= key_q;
      end else if (req && wb_adr == `WDSLP_ADR_STAT) begin
        // read only: writes here never reach the flags
        rdat_q[`WDSLP_BIT_TO]  <= to_q;
        rdat_q[`WDSLP_BIT_PWRDN] <= pwrdn_q;
      end
    end
  end

  assign wb_ack           = ack_q;
  assign wb_dat_r         = rdat_q;
  assign mcu_reset        = in_rst;
  assign pc_sp_reset      = pc_sp_q;
  assign cpu_hold         = ~in_run;
  assign sys_osc_en       = ~in_sleep;
  assign sleeping         = in_sleep;
  assign wake_resume      = resume_q;
  assign irq_service      = service_q;
  assign timeout_flag     = to_q;
  assign power_down_flag  = pwrdn_q;
  assign watchdog_running = key_en & ~in_rst;

endmodule // wdslp_top

// [wdslp_consts.svh]
// Purpose: named offsets, field positions, reset values and timing figures of the watchdog block
// Assumes: included by bare name from the top-level design file only
// Notes:   definitions only
`ifndef WDSLP_CONSTS_SVH
`define WDSLP_CONSTS_SVH

`define WDSLP_ADR_TSEL      8'h00
`define WDSLP_ADR_CTRL      8'h04
`define WDSLP_ADR_STAT      8'h08

`define WDSLP_TSEL_RST      3'h7
`define WDSLP_CLS_RST       2'h0
`define WDSLP_KEY_RST       6'h00

`define WDSLP_KEY_ENABLE    6'h00
`define WDSLP_KEY_DISABLE   6'h2d
`define WDSLP_CLS_SLOW_RC   2'h0
`define WDSLP_CLS_DIV4      2'h1

`define WDSLP_BIT_TO        5
`define WDSLP_BIT_PWRDN     4
`define WDSLP_CLS_HI        7
`define WDSLP_CLS_LO        6
`define WDSLP_KEY_HI        5
`define WDSLP_TSEL_HI       2

`define WDSLP_DIV_BASE      8
`define WDSLP_CNT_W         15
`define WDSLP_PA_WAKE_MASK  8'h27
`define WDSLP_KEY_DLY_TICKS 2'h2

`define WDSLP_SST_CYC       16
`define WDSLP_RSTD_MS       50
`define WDSLP_CLK_KHZ       25000

`endif

// [wdslp_pkg.sv]
// Purpose: types shared by the watchdog and sleep control block
// Assumes: nothing
// Notes:   power state machine codes are one-hot
package wdslp_pkg;

  typedef enum logic [3:0] {
    WDSLP_RUN   = 4'h1,
    WDSLP_SLEEP = 4'h2,
    WDSLP_WAKE  = 4'h4,
    WDSLP_RST   = 4'h8
  } wdslp_state_t;

endpackage

// [wdslp_props.sv]
// Purpose: concurrent checks on the watchdog and sleep block ports
// Assumes: single core_clk domain, sys_rst asynchronous active high
// Notes:   bound to wdslp_top below
module wdslp_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_ack,
  input wire logic [31:0] wb_dat_r,
  input wire logic        sleep_instruction,
  input wire logic        watchdog_clear_instruction,
  input wire logic        mcu_reset,
  input wire logic        pc_sp_reset,
  input wire logic        cpu_hold,
  input wire logic        sys_osc_en,
  input wire logic        sleeping,
  input wire logic        wake_resume,
  input wire logic        irq_service,
  input wire logic        timeout_flag,
  input wire logic        power_down_flag,
  input wire logic        watchdog_running
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus request not acknowledged in next cycle");
  a_idle_data_zero: assert property (!wb_ack |-> wb_dat_r == 32'h0)
    else $error("read data not zero outside ack");
  a_sleep_entry: assert property (sleep_instruction && !cpu_hold && !mcu_reset |=>
    sleeping && power_down_flag && !timeout_flag) else $error("sleep entry wrong");
  a_sleep_osc_off: assert property (sleeping |-> !sys_osc_en && cpu_hold)
    else $error("oscillator or core running in sleep");
  a_clear_pdf: assert property (watchdog_clear_instruction && watchdog_running && !cpu_hold
    && !sleep_instruction |=> !power_down_flag) else $error("clear left power-down flag");
  a_wake_release: assert property ($fell(sleeping) && !mcu_reset |->
    cpu_hold [*8] ##1 cpu_hold [*7] ##[1:2] !cpu_hold) else $error("wake delay not 16 cycles");
  a_strobe_unique: assert property ($onehot0({wake_resume, irq_service, pc_sp_reset}))
    else $error("more than one resume strobe");
  a_resume_edge: assert property (wake_resume || irq_service |-> !cpu_hold && $past(cpu_hold))
    else $error("resume strobe not at end of hold");
  a_overflow_flags: assert property (pc_sp_reset |=> timeout_flag && power_down_flag)
    else $error("sleep overflow flags wrong");
  a_running_key: assert property ($fell(mcu_reset) |-> watchdog_running)
    else $error("watchdog not enabled after device reset");

  c_sleep: cover property (sleep_instruction && !cpu_hold);
  c_irq: cover property (irq_service);
  c_pcsp: cover property (pc_sp_reset);
endmodule // wdslp_props

bind wdslp_top wdslp_props u_wdslp_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack),
  .wb_dat_r(wb_dat_r), .sleep_instruction(sleep_instruction),
  .watchdog_clear_instruction(watchdog_clear_instruction), .mcu_reset(mcu_reset),
  .pc_sp_reset(pc_sp_reset), .cpu_hold(cpu_hold), .sys_osc_en(sys_osc_en), .sleeping(sleeping),
  .wake_resume(wake_resume), .irq_service(irq_service), .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag), .watchdog_running(watchdog_running));

// [test_watchdog_sleep_wakeup_control.sv]
// Purpose: directed tests of sleep, wake and watchdog behaviour
// Assumes: reset delay shortened to 20 cycles, rc clock period 6 core cycles
// Notes:   every input driven by nba right after a rising edge
module test_watchdog_sleep_wakeup_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RSTD = 20;
  logic        core_clk = 1'h0, sys_rst = 1'h1, low_speed_rc_clock = 1'h0;
  logic        wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, stack_full = 1'h0;
  logic [7:0]  wb_adr = 8'h0, port_a_pins = 8'hff, port_a_wake_enable = 8'h0;
  logic [3:0]  wb_sel = 4'hf, irq_request = 4'h0, irq_enable = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd;
  logic        external_reset_pin_n = 1'h1, sleep_instruction = 1'h0;
  logic        watchdog_clear_instruction = 1'h0, wb_ack, mcu_reset, pc_sp_reset, cpu_hold;
  logic        sys_osc_en, sleeping, wake_resume, irq_service, timeout_flag, power_down_flag;
  logic        watchdog_running;
  logic [2:0]  rc_div = 3'h0;
  int          miscompares = 0, check_count = 0, cyc_n = 0, n;
  wire  [5:0]  ev = {!mcu_reset, mcu_reset, pc_sp_reset, irq_service, wake_resume, sleeping};

  wdslp_top #(.RSTD_CYC(RSTD)) u_wdslp_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .low_speed_rc_clock(low_speed_rc_clock), .external_reset_pin_n(external_reset_pin_n),
    .port_a_pins(port_a_pins), .port_a_wake_enable(port_a_wake_enable),
    .irq_request(irq_request), .irq_enable(irq_enable), .stack_full(stack_full),
    .sleep_instruction(sleep_instruction), .watchdog_clear_instruction(watchdog_clear_instruction),
    .mcu_reset(mcu_reset), .pc_sp_reset(pc_sp_reset), .cpu_hold(cpu_hold), .sys_osc_en(sys_osc_en),
    .sleeping(sleeping), .wake_resume(wake_resume), .irq_service(irq_service),
    .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
    .watchdog_running(watchdog_running));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    rc_div <= (rc_div == 3'h2) ? 3'h0 : rc_div + 3'h1;
    if (rc_div == 3'h2) low_speed_rc_clock <= ~low_speed_rc_clock;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // values read just after an edge are those launched by the edge before
  task automatic wait_ev(input string nm, input int b, input int lim, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (ev[b] !== 1'h1 && k < lim);
    chk(nm, 1'h1, ev[b]);
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack !== 1'h1 && k < 20);
    q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    chk("ack", 1'h1, wb_ack);
  endtask

  task automatic pulse(input logic clr);
    @(posedge core_clk);
    if (clr) watchdog_clear_instruction <= 1'h1;
    else sleep_instruction <= 1'h1;
    @(posedge core_clk);
    sleep_instruction <= 1'h0;
    watchdog_clear_instruction <= 1'h0;
  endtask

  task automatic t_regs;
    wb(1'h0, 8'h00, 32'h0, rd);
    chk("tsel reset", 32'h7, rd);
    wb(1'h0, 8'h04, 32'h0, rd);
    chk("ctrl reset", 32'h0, rd);
    wb(1'h0, 8'h0c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wb(1'h1, 8'h00, 32'h5, rd);
    wb(1'h0, 8'h00, 32'h0, rd);
    chk("tsel rw", 32'h5, rd);
    $display("done regs");
  endtask

  task automatic t_pin_wake;
    wb(1'h1, 8'h04, 32'h2d, rd);
    port_a_wake_enable <= 8'h28;
    pulse(1'h0);
    tick(1);
    chk("sleeping", 1'h1, sleeping);
    chk("osc off", 1'h0, sys_osc_en);
    chk("pdf set", 1'h1, power_down_flag);
    chk("to clear", 1'h0, timeout_flag);
    chk("wdt off", 1'h0, watchdog_running);
    chk("core held", 1'h1, cpu_hold);
    port_a_pins[3] <= 1'h0;
    tick(12);
    chk("masked pin", 1'h1, sleeping);
    port_a_pins[5] <= 1'h0;
    wait_ev("pin wake", 1, 40, n);
    chk("wake delay", 1'h1, n >= 16);
    port_a_pins <= 8'hff;
    pulse(1'h1);
    tick(1);
    chk("noop clear", 1'h1, power_down_flag);
    wb(1'h1, 8'h08, 32'h0, rd);
    wb(1'h0, 8'h08, 32'h0, rd);
    chk("status ro", 32'h10, rd);
    $display("done pin wake");
  endtask

  task automatic t_irq_wake;
    irq_request <= 4'h1;
    irq_enable <= 4'h2;
    pulse(1'h0);
    tick(10);
    chk("stale irq", 1'h1, sleeping);
    irq_request <= 4'h3;
    wait_ev("irq service", 2, 40, n);
    irq_request <= 4'h0;
    irq_enable <= 4'h4;
    stack_full <= 1'h1;
    pulse(1'h0);
    tick(2);
    irq_request <= 4'h4;
    wait_ev("irq stack full", 1, 40, n);
    irq_request <= 4'h0;
    stack_full <= 1'h0;
    $display("done irq wake");
  endtask

  task automatic t_sleep_overflow;
    wb(1'h1, 8'h00, 32'h0, rd);
    wb(1'h1, 8'h04, 32'h80, rd);
    pulse(1'h0);
    tick(400);
    chk("sysclk stops", 1'h1, sleeping);
    port_a_pins[5] <= 1'h0;
    wait_ev("pin wake 2", 1, 40, n);
    port_a_pins <= 8'hff;
    wb(1'h1, 8'h04, 32'h0, rd);
    pulse(1'h0);
    wait_ev("sleep overflow", 3, 2500, n);
    tick(1);
    chk("to set", 1'h1, timeout_flag);
    chk("pdf kept", 1'h1, power_down_flag);
    $display("done sleep overflow");
  endtask

  task automatic t_norm_overflow;
    tick(20);
    pulse(1'h1);
    tick(1);
    chk("clear pdf", 1'h0, power_down_flag);
    repeat (3) begin
      tick(1000);
      pulse(1'h1);
    end
    chk("kept alive", 1'h0, timeout_flag);
    wait_ev("run overflow", 4, 2000, n);
    tick(1);
    chk("to run", 1'h1, timeout_flag);
    wait_ev("reset end", 5, 100, n);
    wb(1'h0, 8'h00, 32'h0, rd);
    chk("defaults", 32'h7, rd);
    $display("done run overflow");
  endtask

  task automatic t_bad_key;
    wb(1'h1, 8'h04, 32'h01, rd);
    wait_ev("bad key", 4, 30, n);
    chk("key delay", 1'h1, n >= 12 && n <= 18);
    wait_ev("bad key end", 5, 100, n);
    wb(1'h0, 8'h04, 32'h0, rd);
    chk("key default", 32'h0, rd);
    $display("done bad key");
  endtask

  task automatic t_pin_reset;
    external_reset_pin_n <= 1'h0;
    wait_ev("pin reset", 4, 10, n);
    tick(5);
    external_reset_pin_n <= 1'h1;
    wait_ev("pin reset end", 5, 80, n);
    chk("reset delay", 1'h1, n >= RSTD);
    chk("to kept", 1'h1, timeout_flag);
    $display("done pin reset");
  endtask

  // system clock / 4 source: 2^8 ticks of every fourth cycle; prescaler phase adds up to 3
  task automatic t_fast_overflow;
    tick(20);
    wb(1'h1, 8'h00, 32'h0, rd);
    wb(1'h1, 8'h04, 32'h40, rd);
    pulse(1'h1);
    wait_ev("div4 overflow", 4, 1100, n);
    chk("div4 period", 1'h1, n > 1021 && n < 1026);
    $display("done div4 overflow");
  endtask

  initial begin
    tick(2);
    sys_rst <= 1'h0;
    tick(3);
    t_regs();
    t_pin_wake();
    t_irq_wake();
    t_sleep_overflow();
    t_norm_overflow();
    t_bad_key();
    t_pin_reset();
    t_fast_overflow();
    wrap_up();
  end
endmodule // test_watchdog_sleep_wakeup_control
